// ===== design/uart_top.sv
// Notes on behaviour
// [RL1] Divisor is high and low byte together
// [RL2] Baud equals reference over sixteen times divisor
// [RL3] Line status shows all empty and room
// [RL4] FIFO control bit picks DMA signalling
// [RL5] Non-DMA: interrupt per character transferred
// [RL6] DMA: interrupt on transmit room, receive trigger
// [RL7] Power down needs both enable bits set
// [RL8] Clearing either bit leaves power down
// [RL9] Loop-back joins transmitter to receiver internally
// [RL10] Loop-back ignores external modem inputs
// [RL11] Loop-back feeds modem inputs from control bits
// [RL12] Looped bytes return through receive holding
// [RL13] Loop-back holds int_out low; irq_out events still work
// [RL14] Loop-back modem state seen in control bits
// [RL15] Sixteen ticks per bit, divisor 1..65535
// [RL16] Divisor reachable only with access bit set
// [RL17] FIFOs deep only while enable bit set
// [RL18] Loop-back follows its control bit
// [RL19] Power down keeps registers and divisor
`timescale 1ns/10ps
`default_nettype none
module uart_top
   import uart_pkg::*;
#(
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   // Clock, reset, enable
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   // AHB-Lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic [31:0] hrdata_out,
   // Serial line and modem pins
   input wire logic rx_in,
   input wire logic cts_n_in,
   input wire logic dsr_n_in,
   input wire logic cd_n_in,
   input wire logic ri_n_in,
   output logic tx_out,
   output logic dtr_n_out,
   output logic rts_n_out,
   // Interrupts and power
   output logic int_out,
   output logic irq_out,
   output logic pwrdn_out
);
   localparam int PW = $clog2(DEPTH);

   // Pointers wrap by width, so depth must be a power of two
   if (DEPTH < 2 || DEPTH > 16 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("DEPTH must be a power of two from 2 to 16");
   end

   typedef struct packed {
      logic ap_v;
      logic ap_w;
      logic [3:0] ap_idx;
      logic rd_done;
      logic [31:0] rdata;
      logic [7:0] dll;
      logic [7:0] divisor_high_byte;
      logic [7:0] interrupt_enable_reg;
      logic [7:0] fifo_control_reg;
      logic [7:0] line_control_reg;
      logic [7:0] modem_control_reg;
      logic [7:0] spr;
      logic [DEPTH-1:0][7:0] txq;
      logic [DEPTH-1:0][7:0] rxq;
      logic [PW:0] tx_cnt;
      logic [PW:0] rx_cnt;
      logic [PW-1:0] tx_rd;
      logic [PW-1:0] rx_rd;
      logic [9:0] tx_sh;
      logic [3:0] tx_bits;
      logic [3:0] tx_sub;
      logic tx_busy;
      logic [7:0] rx_sh;
      logic [3:0] rx_bits;
      logic [3:0] rx_sub;
      logic rx_busy;
      logic oe;
      logic fe;
      logic [3:0] msr_prev;
      logic [3:0] delta;
      logic [EV_W-1:0] evt;
      logic [EV_W-1:0] mask;
   } st_t;

   st_t s_ff, nxt_s;
   baud_if bif();
   logic lb, dlab, fifo_on, dma, tx_line, rx_line;
   logic [3:0] modem;
   logic [PW:0] cap;
   logic rx_cond, tx_cond, int_pend;
   logic [2:0] int_id;
   logic [7:0] lsr_val, wb, rv;
   logic tx_push, tx_pop, rx_push, rx_pop, tx_clr, rx_clr;
   logic [EV_W-1:0] ev;
   logic [3:0] chg;

   baud_gen u_baud (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .ce_in(ce_in),
      .bif(bif)
   );

   // Generator output is 16x the bit rate: ref / (16 * divisor)
   assign bif.divisor = {s_ff.divisor_high_byte, s_ff.dll}; // RL1 RL2 RL15
   assign pwrdn_out = s_ff.modem_control_reg[MCR_PD] & s_ff.interrupt_enable_reg[IER_PD]; // RL7 RL8
   assign bif.run = !pwrdn_out; // RL19

   assign lb = s_ff.modem_control_reg[MCR_LOOP]; // RL18
   assign dlab = s_ff.line_control_reg[LCR_DLAB];
   assign fifo_on = s_ff.fifo_control_reg[FCR_EN];
   assign dma = fifo_on & s_ff.fifo_control_reg[FCR_DMA]; // RL4
   assign cap = fifo_on ? (PW+1)'(DEPTH) : (PW+1)'(1); // RL17
   // Break holds the line low regardless of the shifter
   assign tx_line = !s_ff.line_control_reg[LCR_BRK] & (!s_ff.tx_busy | s_ff.tx_sh[0]);
   assign tx_out = lb | tx_line; // RL9
   assign rx_line = lb ? tx_line : rx_in; // RL9 RL12
   // Order CD, RI, DSR, CTS as in the status byte
   assign modem = lb ? s_ff.modem_control_reg[3:0] // RL11
                     : ~{cd_n_in, ri_n_in, dsr_n_in, cts_n_in}; // RL10
   assign dtr_n_out = lb | !s_ff.modem_control_reg[MCR_DTR];
   assign rts_n_out = lb | !s_ff.modem_control_reg[MCR_RTS];

   assign rx_cond = dma ? (5'(s_ff.rx_cnt) > rx_trig(s_ff.fifo_control_reg[7:6]))
                        : (s_ff.rx_cnt != '0); // RL5 RL6
   assign tx_cond = dma ? (s_ff.tx_cnt < (PW+1)'(DEPTH))
                        : (s_ff.tx_cnt == '0); // RL5 RL6
   assign int_pend = (s_ff.interrupt_enable_reg[0] & rx_cond) | (s_ff.interrupt_enable_reg[1] & tx_cond)
                   | (s_ff.interrupt_enable_reg[2] & (s_ff.oe | s_ff.fe))
                   | (s_ff.interrupt_enable_reg[3] & (|s_ff.delta)); // RL13
   assign int_out = int_pend & s_ff.modem_control_reg[MCR_INTEN] & !lb;
   assign irq_out = |(s_ff.evt & s_ff.mask);

   always_comb begin
      if (s_ff.interrupt_enable_reg[2] & (s_ff.oe | s_ff.fe)) begin
         int_id = ID_LINE;
      end else if (s_ff.interrupt_enable_reg[0] & rx_cond) begin
         int_id = ID_RX;
      end else if (s_ff.interrupt_enable_reg[1] & tx_cond) begin
         int_id = ID_TX;
      end else begin
         int_id = ID_MODEM;
      end
   end

   assign lsr_val = {1'b0, (s_ff.tx_cnt == '0) & !s_ff.tx_busy,
                     s_ff.tx_cnt < cap, 1'b0, s_ff.fe, 1'b0, s_ff.oe,
                     s_ff.rx_cnt != '0}; // RL3
   assign wb = hwdata_in[7:0];
   assign chg = modem ^ s_ff.msr_prev;

   assign hreadyout_out = !(s_ff.ap_v & !s_ff.ap_w & !s_ff.rd_done);
   assign hresp_out = 1'b0;
   assign hrdata_out = s_ff.rdata;

   always_comb begin
      nxt_s = s_ff;
      rv = 8'h00;
      ev = '0;
      tx_push = 1'b0;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      tx_clr = 1'b0;
      rx_clr = 1'b0;
      // Bus data phase; reads wait one cycle so data comes from a flop
      if (s_ff.ap_v) begin
         if (s_ff.ap_w) begin
            nxt_s.ap_v = 1'b0;
            case (s_ff.ap_idx)
               IDX_DATA: begin
                  if (dlab) begin
                     nxt_s.dll = wb; // RL16
                  end else begin
                     tx_push = 1'b1; // RL12
                  end
               end
               IDX_IER: begin
                  if (dlab) begin
                     nxt_s.divisor_high_byte = wb; // RL16
                  end else begin
                     nxt_s.interrupt_enable_reg = wb & IER_KEEP;
                  end
               end
               IDX_ISR_FCR: begin
                  nxt_s.fifo_control_reg = wb & FCR_KEEP;
                  // Changing depth empties both queues so no count exceeds it
                  rx_clr = wb[FCR_RXRST] | (wb[FCR_EN] != fifo_on); // RL17
                  tx_clr = wb[FCR_TXRST] | (wb[FCR_EN] != fifo_on);
               end
               IDX_LCR: nxt_s.line_control_reg = wb;
               IDX_MCR: nxt_s.modem_control_reg = wb & MCR_KEEP;
               IDX_SPR: nxt_s.spr = wb;
               IDX_MASK: nxt_s.mask = wb[EV_W-1:0];
               default: ;
            endcase
         end else if (!s_ff.rd_done) begin
            nxt_s.rd_done = 1'b1;
            case (s_ff.ap_idx)
               IDX_DATA: begin
                  if (dlab) begin
                     rv = s_ff.dll;
                  end else begin
                     rv = s_ff.rxq[s_ff.rx_rd];
                     rx_pop = s_ff.rx_cnt != '0;
                  end
               end
               IDX_IER: rv = dlab ? s_ff.divisor_high_byte : s_ff.interrupt_enable_reg;
               IDX_ISR_FCR: rv = {{2{fifo_on}}, 2'b00, int_id, !int_pend};
               IDX_LCR: rv = s_ff.line_control_reg;
               IDX_MCR: rv = s_ff.modem_control_reg; // RL14
               IDX_LSR: begin
                  rv = lsr_val;
                  nxt_s.oe = 1'b0;
                  nxt_s.fe = 1'b0;
               end
               IDX_MSR: begin
                  rv = {lb ? 4'h0 : modem, s_ff.delta}; // RL14
                  nxt_s.delta = 4'h0;
               end
               IDX_SPR: rv = s_ff.spr;
               IDX_EVT: begin
                  rv = 8'(s_ff.evt);
                  nxt_s.evt = '0;
               end
               IDX_MASK: rv = 8'(s_ff.mask);
               default: rv = 8'h00;
            endcase
            nxt_s.rdata = {24'h000000, rv};
         end else begin
            nxt_s.ap_v = 1'b0;
            nxt_s.rd_done = 1'b0;
         end
      end
      if (hsel_in & htrans_in[1] & hready_in) begin
         nxt_s.ap_v = 1'b1;
         nxt_s.ap_w = hwrite_in;
         nxt_s.rd_done = 1'b0;
         nxt_s.ap_idx = (haddr_in[31:6] == '0) ? haddr_in[5:2] : IDX_NONE;
      end

      // Transmitter: start, eight data bits LSB first, stop
      if (!s_ff.tx_busy) begin
         if (s_ff.tx_cnt != '0) begin
            nxt_s.tx_sh = {1'b1, s_ff.txq[s_ff.tx_rd], 1'b0};
            nxt_s.tx_busy = 1'b1;
            nxt_s.tx_bits = 4'h0;
            nxt_s.tx_sub = 4'h0;
            tx_pop = 1'b1;
         end
      end else if (bif.tick) begin
         nxt_s.tx_sub = 4'(s_ff.tx_sub + 4'h1); // RL15
         if (s_ff.tx_sub == TICK_LAST) begin
            nxt_s.tx_sh = {1'b1, s_ff.tx_sh[9:1]};
            nxt_s.tx_bits = 4'(s_ff.tx_bits + 4'h1);
            if (s_ff.tx_bits == BITS_STOP) begin
               nxt_s.tx_busy = 1'b0;
               ev[EV_TX] = 1'b1; // RL5
            end
         end
      end

      // Receiver: a start bit still low at mid-bit opens a frame
      if (bif.tick) begin
         if (!s_ff.rx_busy) begin
            if (!rx_line) begin
               nxt_s.rx_busy = 1'b1;
               nxt_s.rx_sub = 4'h0;
               nxt_s.rx_bits = 4'h0;
            end
         end else begin
            nxt_s.rx_sub = 4'(s_ff.rx_sub + 4'h1); // RL15
            if (s_ff.rx_sub == TICK_MID) begin
               nxt_s.rx_bits = 4'(s_ff.rx_bits + 4'h1);
               if (s_ff.rx_bits == 4'h0) begin
                  nxt_s.rx_busy = !rx_line;
               end else if (s_ff.rx_bits < BITS_STOP) begin
                  nxt_s.rx_sh = {rx_line, s_ff.rx_sh[7:1]};
               end else begin
                  nxt_s.rx_busy = 1'b0;
                  rx_push = 1'b1; // RL12
                  if (!rx_line) begin
                     nxt_s.fe = 1'b1;
                     ev[EV_LINE] = 1'b1;
                  end
               end
            end
         end
      end

      // Queues; a full receive queue drops the byte and flags overrun
      if (tx_push && s_ff.tx_cnt < cap) begin
         nxt_s.txq[PW'(s_ff.tx_rd + s_ff.tx_cnt[PW-1:0])] = wb;
         nxt_s.tx_cnt = (PW+1)'(nxt_s.tx_cnt + (PW+1)'(1));
      end
      if (tx_pop) begin
         nxt_s.tx_cnt = (PW+1)'(nxt_s.tx_cnt - (PW+1)'(1));
         nxt_s.tx_rd = PW'(s_ff.tx_rd + PW'(1));
      end
      if (rx_push) begin
         if (s_ff.rx_cnt < cap) begin
            nxt_s.rxq[PW'(s_ff.rx_rd + s_ff.rx_cnt[PW-1:0])] = s_ff.rx_sh;
            nxt_s.rx_cnt = (PW+1)'(nxt_s.rx_cnt + (PW+1)'(1));
            ev[EV_RX] = 1'b1; // RL5
         end else begin
            nxt_s.oe = 1'b1;
            ev[EV_LINE] = 1'b1;
         end
      end
      if (rx_pop) begin
         nxt_s.rx_cnt = (PW+1)'(nxt_s.rx_cnt - (PW+1)'(1));
         nxt_s.rx_rd = PW'(s_ff.rx_rd + PW'(1));
      end
      if (tx_clr) begin
         nxt_s.tx_cnt = '0;
         nxt_s.tx_rd = '0;
      end
      if (rx_clr) begin
         nxt_s.rx_cnt = '0;
         nxt_s.rx_rd = '0;
      end

      // Modem changes; a change in a clearing read still sticks
      nxt_s.msr_prev = modem;
      nxt_s.delta = nxt_s.delta | chg; // RL13
      ev[EV_MODEM] = |chg;
      nxt_s.evt = nxt_s.evt | ev;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         s_ff <= '0;
         s_ff.spr <= SPR_RST;
         s_ff.modem_control_reg <= REG_RST;
      end else if (ce_in) begin
         s_ff <= nxt_s;
      end
   end

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!nrst_in || !ce_in);

   property p_pd_enter;
      s_ff.ap_v && s_ff.ap_w && s_ff.ap_idx == IDX_MCR
         && hwdata_in[MCR_PD] && s_ff.interrupt_enable_reg[IER_PD] |=> pwrdn_out;
   endproperty
   a_pd_enter: assert property (p_pd_enter) // RL7
      else $error("power down not entered");

   property p_pd_exit;
      $fell(s_ff.interrupt_enable_reg[IER_PD]) || $fell(s_ff.modem_control_reg[MCR_PD]) |-> !pwrdn_out;
   endproperty
   a_pd_exit: assert property (p_pd_exit) // RL8
      else $error("power down not left");

   property p_pd_still;
      pwrdn_out && $past(pwrdn_out) |-> !bif.tick && $stable(bif.divisor);
   endproperty
   a_pd_still: assert property (p_pd_still) // RL19
      else $error("baud activity while powered down");

   property p_loop_tx;
      lb |-> tx_out && dtr_n_out && rts_n_out;
   endproperty
   a_loop_tx: assert property (p_loop_tx) // RL9
      else $error("pins driven in loop-back");

   // Captured modem state must be the looped control bits, never the pins
   property p_loop_modem;
      $past(lb) && $past(ce_in) && $past(nrst_in)
         |-> s_ff.msr_prev == $past(s_ff.modem_control_reg[3:0]);
   endproperty
   a_loop_modem: assert property (p_loop_modem) // RL10
      else $error("external modem input seen in loop-back");

   property p_tx_empty;
      s_ff.tx_cnt == '0 && !s_ff.tx_busy |-> lsr_val[6] && lsr_val[5];
   endproperty
   a_tx_empty: assert property (p_tx_empty) // RL3
      else $error("transmitter empty not reported");

   property p_int_dma;
      dma && s_ff.interrupt_enable_reg[0] && s_ff.modem_control_reg[MCR_INTEN] && !lb
         && 5'(s_ff.rx_cnt) > rx_trig(s_ff.fifo_control_reg[7:6]) |-> int_out;
   endproperty
   a_int_dma: assert property (p_int_dma) // RL6
      else $error("receive trigger interrupt missing");

   property p_int_single;
      !dma && s_ff.interrupt_enable_reg[1] && s_ff.modem_control_reg[MCR_INTEN] && !lb
         && s_ff.tx_cnt == '0 |-> int_out;
   endproperty
   a_int_single: assert property (p_int_single) // RL5
      else $error("transmit interrupt missing");

   property p_dlab;
      s_ff.ap_v && s_ff.ap_w && s_ff.ap_idx == IDX_DATA && !dlab
         |=> $stable(s_ff.dll);
   endproperty
   a_dlab: assert property (p_dlab) // RL16
      else $error("divisor written without access bit");

   property p_tick_gap;
      bif.tick && bif.divisor > 16'h0001 && $stable(bif.divisor)
         |=> !bif.tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) // RL2
      else $error("baud ticks closer than divisor");

   property p_fifo_off;
      !fifo_on |-> s_ff.tx_cnt <= (PW+1)'(1) && s_ff.rx_cnt <= (PW+1)'(1);
   endproperty
   a_fifo_off: assert property (p_fifo_off) // RL17
      else $error("queue deeper than one with FIFOs off");

   c_loop_rx: cover property (lb && rx_push);
   c_pd: cover property ($rose(pwrdn_out));
   c_dma_int: cover property (dma && $rose(int_out));
   c_overrun: cover property ($rose(s_ff.oe));
endmodule
`default_nettype wire

// ===== design/uart_pkg.sv
package uart_pkg;
   localparam int unsigned FIFO_DEPTH = 16;
   // Register indices; the byte address is four times the index
   localparam logic [3:0] IDX_DATA = 4'h0;
   localparam logic [3:0] IDX_IER = 4'h1;
   localparam logic [3:0] IDX_ISR_FCR = 4'h2;
   localparam logic [3:0] IDX_LCR = 4'h3;
   localparam logic [3:0] IDX_MCR = 4'h4;
   localparam logic [3:0] IDX_LSR = 4'h5;
   localparam logic [3:0] IDX_MSR = 4'h6;
   localparam logic [3:0] IDX_SPR = 4'h7;
   localparam logic [3:0] IDX_EVT = 4'h8;
   localparam logic [3:0] IDX_MASK = 4'h9;
   localparam logic [3:0] IDX_NONE = 4'hF;
   // Field positions
   localparam int LCR_DLAB = 7;
   localparam int LCR_BRK = 6;
   localparam int FCR_EN = 0;
   localparam int FCR_RXRST = 1;
   localparam int FCR_TXRST = 2;
   localparam int FCR_DMA = 3;
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_INTEN = 3;
   localparam int MCR_LOOP = 4;
   localparam int MCR_PD = 7;
   localparam int IER_PD = 5;
   localparam logic [7:0] IER_KEEP = 8'h2F;
   localparam logic [7:0] FCR_KEEP = 8'hC9;
   localparam logic [7:0] MCR_KEEP = 8'h9F;
   // Reset values
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] SPR_RST = 8'hFF;
   // Sixteen ticks per bit, sampled mid-bit; frame is start, 8 data, stop
   localparam logic [3:0] TICK_MID = 4'h7;
   localparam logic [3:0] TICK_LAST = 4'hF;
   localparam logic [3:0] BITS_STOP = 4'h9;
   // Sticky event bits
   localparam int EV_RX = 0;
   localparam int EV_TX = 1;
   localparam int EV_LINE = 2;
   localparam int EV_MODEM = 3;
   localparam int EV_W = 4;
   // Interrupt identification codes
   localparam logic [2:0] ID_LINE = 3'h3;
   localparam logic [2:0] ID_RX = 3'h2;
   localparam logic [2:0] ID_TX = 3'h1;
   localparam logic [2:0] ID_MODEM = 3'h0;

   function automatic logic [4:0] rx_trig(input logic [1:0] sel);
      case (sel)
         2'h0: rx_trig = 5'h01;
         2'h1: rx_trig = 5'h04;
         2'h2: rx_trig = 5'h08;
         default: rx_trig = 5'h0E;
      endcase
   endfunction
endpackage

// ===== design/baud_if.sv
`timescale 1ns/10ps
`default_nettype none
interface baud_if;
   logic [15:0] divisor;
   logic run;
   logic tick;
   modport ctl(output divisor, output run, input tick);
   modport gen(input divisor, input run, output tick);
endinterface
`default_nettype wire

// ===== design/baud_gen.sv
`timescale 1ns/10ps
`default_nettype none
module baud_gen (
   // Clock, reset, enable
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   // Divisor and tick
   baud_if.gen bif
);
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } bg_st_t;
   bg_st_t s_ff, nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.tick = 1'b0;
      // Count is held, not cleared, while stopped so the rate resumes
      if (bif.run && bif.divisor != 16'h0000) begin
         if (s_ff.cnt >= 16'(bif.divisor - 16'h0001)) begin
            nxt_s.cnt = 16'h0000;
            nxt_s.tick = 1'b1;
         end else begin
            nxt_s.cnt = 16'(s_ff.cnt + 16'h0001);
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         s_ff <= '0;
      end else if (ce_in) begin
         s_ff <= nxt_s;
      end
   end

   assign bif.tick = s_ff.tick;
endmodule
`default_nettype wire

// ===== bench/serial_peer.sv
`timescale 1ns/10ps
`default_nettype none
module serial_peer #(
   parameter int BIT_CLKS = 32
) (
   // Clock
   input wire logic clk_in,
   // Serial lines
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] got_q[$];
   logic [7:0] acc;

   initial line_out = 1'h1;

   // Frames go LSB first with one stop bit; the line idles high
   task automatic send(input logic [7:0] d);
      line_out <= 1'h0;
      repeat (BIT_CLKS) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
         line_out <= d[i];
         repeat (BIT_CLKS) @(posedge clk_in);
      end
      line_out <= 1'h1;
      repeat (BIT_CLKS) @(posedge clk_in);
   endtask

   // Mid-bit sampling: a wrong bit time shows up as bad data or no stop
   initial begin
      acc = 8'h00;
      forever begin
         @(posedge clk_in iff line_in === 1'h0);
         repeat (BIT_CLKS / 2) @(posedge clk_in);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk_in);
            acc[i] = line_in;
         end
         repeat (BIT_CLKS) @(posedge clk_in);
         if (line_in === 1'h1) got_q.push_back(acc);
         @(posedge clk_in iff line_in === 1'h1);
      end
   end
endmodule
`default_nettype wire

// ===== bench/test_uart_baud_dma_powerdown_loopback.sv
`timescale 1ns/10ps
`default_nettype none
module test_uart_baud_dma_powerdown_loopback;
   import uart_pkg::*;
   // Divisor 2 gives sixteen times two clocks per bit
   localparam int BITC = 32;
   logic clk, nrst, hsel, hwrite, ready, resp, tx, rx, intr, irq, pd;
   logic dtr_n, rts_n, cts_n, dsr_n, cd_n, ri_n;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] v, b;
   logic [7:0] exp_q[$];
   int fails, samples_checked, bad;

   uart_top dut_u (.sys_clk_in(clk), .nrst_in(nrst), .ce_in(1'h1),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(ready), .hreadyout_out(ready), .hresp_out(resp),
      .hrdata_out(hrdata), .rx_in(rx), .cts_n_in(cts_n),
      .dsr_n_in(dsr_n), .cd_n_in(cd_n), .ri_n_in(ri_n), .tx_out(tx),
      .dtr_n_out(dtr_n), .rts_n_out(rts_n), .int_out(intr),
      .irq_out(irq), .pwrdn_out(pd));

   serial_peer #(.BIT_CLKS(BITC)) peer_u (.clk_in(clk), .line_in(tx),
      .line_out(rx));

   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   task automatic test_done;
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Single word transfer; address held until ready, then data phase
   task automatic bus(input logic w, input logic [3:0] idx,
                      input logic [7:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {26'h0, idx, 2'h0};
      hwrite <= w;
      do @(posedge clk); while (ready !== 1'h1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge clk); while (ready !== 1'h1);
      v = hrdata[7:0];
      chk({15'h0, resp}, 16'h0000);
   endtask

   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      bus(1'h1, idx, d);
   endtask

   task automatic rd(input logic [3:0] idx);
      bus(1'h0, idx, 8'h00);
   endtask

   task automatic rx_byte(input logic [7:0] d);
      exp_q.push_back(d);
      peer_u.send(d);
      @(posedge clk);
   endtask

   task automatic pop_rx;
      rd(IDX_DATA);
      chk(v, exp_q.pop_front());
   endtask

   // Frame length bounds catch a divisor that was not applied
   task automatic tx_byte;
      b = $urandom;
      wr(IDX_DATA, b);
      rd(IDX_LSR);
      chk(v[6], 1'h0);
      bad = 0;
      while (peer_u.got_q.size() == 0 && bad < 1000) begin
         @(posedge clk);
         bad++;
      end
      chk(peer_u.got_q.size(), 1);
      if (peer_u.got_q.size() > 0) chk(peer_u.got_q.pop_front(), b);
      chk(bad >= 9 * BITC && bad <= 11 * BITC, 1);
      repeat (BITC) @(posedge clk);
      rd(IDX_LSR);
      chk(v & 8'h60, 8'h60);
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      test_done;
   end

   initial begin
      nrst = 1'h0;
      hsel = 1'h0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'h0;
      hwdata = 32'h0;
      {cts_n, dsr_n, cd_n, ri_n} = 4'hF;
      fails = 0;
      samples_checked = 0;
      void'($urandom(32'hF650EB03));
      repeat (20) @(posedge clk);
      nrst <= 1'h1;
      rd(IDX_LSR);
      chk(v, 8'h60);
      rd(IDX_SPR);
      chk(v, 8'hFF);
      rd(4'hC);
      chk(v, 8'h00);
      wr(IDX_IER, 8'h01);
      wr(IDX_LCR, 8'h80);
      wr(IDX_DATA, 8'h02);
      wr(IDX_IER, 8'h00);
      rd(IDX_DATA);
      chk(v, 8'h02);
      wr(IDX_LCR, 8'h03);
      rd(IDX_IER);
      chk(v, 8'h01);
      tx_byte;
      // Event path: raise, clear by read, then mask off
      wr(IDX_MASK, 8'h01);
      rd(IDX_EVT);
      rx_byte($urandom);
      chk(irq, 1'h1);
      rd(IDX_EVT);
      chk(v & 8'h01, 8'h01);
      @(posedge clk);
      chk(irq, 1'h0);
      // Queue is one deep with FIFOs off: drain before the next frame
      pop_rx;
      wr(IDX_MASK, 8'h00);
      rx_byte($urandom);
      chk(irq, 1'h0);
      pop_rx;
      // Single-character against block signalling
      wr(IDX_ISR_FCR, 8'h01);
      wr(IDX_MCR, 8'h08);
      rx_byte($urandom);
      chk(intr, 1'h1);
      rd(IDX_ISR_FCR);
      chk(v, 8'hC4);
      pop_rx;
      @(posedge clk);
      chk(intr, 1'h0);
      wr(IDX_IER, 8'h03);
      @(posedge clk);
      chk(intr, 1'h1);
      wr(IDX_IER, 8'h01);
      wr(IDX_ISR_FCR, 8'h09);
      rx_byte($urandom);
      chk(intr, 1'h0);
      rx_byte($urandom);
      chk(intr, 1'h1);
      pop_rx;
      pop_rx;
      // Loop-back: pins released, data returns internally
      wr(IDX_MCR, 8'h1B);
      {cts_n, dsr_n, cd_n, ri_n} <= 4'($urandom);
      @(posedge clk);
      chk({dtr_n, rts_n}, 2'h3);
      b = $urandom;
      exp_q.push_back(b);
      wr(IDX_DATA, b);
      bad = 0;
      repeat (12 * BITC) begin
         @(posedge clk);
         if (tx !== 1'h1) bad++;
      end
      chk(bad, 0);
      pop_rx;
      rd(IDX_MSR);
      chk(v[7:4], 4'h0);
      chk(v[3:0], 4'hB);
      chk(intr, 1'h0);
      wr(IDX_MCR, 8'h03);
      @(posedge clk);
      chk({dtr_n, rts_n}, 2'h0);
      // Power-down needs both keys; clearing the IER key releases it
      wr(IDX_IER, 8'h20);
      @(posedge clk);
      chk(pd, 1'h0);
      wr(IDX_MCR, 8'h80);
      @(posedge clk);
      chk(pd, 1'h1);
      wr(IDX_IER, 8'h00);
      @(posedge clk);
      chk(pd, 1'h0);
      tx_byte;
      test_done;
   end
endmodule
`default_nettype wire
